/* File: bench/tb_top.sv */
module tb_top
  import pll_regs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clock;
  logic reset_n;
  logic psel;
  logic penable;
  logic pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata;
  logic [DATA_W-1:0] prdata;
  logic pready;
  logic pslverr;
  logic sync_event;
  logic [CHANNELS-1:0] channel_on_synth_a;
  logic [CHANNELS-1:0] channel_resync;
  ratio_t ratios;
  logic synth_a_enable;
  logic synth_a_cal_reset;
  logic synth_a_cal_busy;
  logic primary_ref_doubler_en;
  logic synth_a_resync_enable;
  int fails;
  int check_count;
  logic [7:0] mdl [0:4];
  logic [INDEX_W-1:0] idx_tab [0:4] = '{IDX_PLL2_M_DIV, IDX_PLL1_CTRL_ZERO, IDX_PLL1_CTRL_ONE,
                                        IDX_PLL1_FB_HIGH, IDX_PLL1_FB_LOW};
  logic [7:0] mask_tab [0:4] = '{8'h1f, 8'h1f, 8'h3f, 8'h0f, 8'hff};
  logic [7:0] rst_tab [0:4] = '{8'h00, 8'h1e, 8'h18, 8'h00, 8'h66};
  logic [15:0] corner [0:18] = '{16'h0000, 16'h0001, 16'h001f, 16'h0102, 16'h0106, 16'h010a,
                                 16'h011e, 16'h0200, 16'h0201, 16'h0207, 16'h0208, 16'h0209,
                                 16'h021f, 16'h0300, 16'h0400, 16'h0401, 16'h0402, 16'h030f,
                                 16'h04ff};

  pll_divider_control_regs i_dut (
    .clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sync_event(sync_event), .channel_on_synth_a(channel_on_synth_a),
    .channel_resync(channel_resync), .ratios(ratios), .synth_a_enable(synth_a_enable),
    .synth_a_cal_reset(synth_a_cal_reset), .synth_a_cal_busy(synth_a_cal_busy),
    .primary_ref_doubler_en(primary_ref_doubler_en),
    .synth_a_resync_enable(synth_a_resync_enable)
  );

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  function automatic ratio_t exp_ratio();
    ratio_t r;
    logic [4:0] m;
    logic [2:0] p;
    logic [11:0] f;
    logic [3:0] c;
    m = mdl[0][4:0];
    p = mdl[1][4:2];
    f = {mdl[3][3:0], mdl[4]};
    c = mdl[2][3:0];
    r.m_bypass = (m == 5'h00);
    r.m_ratio = (m == 5'h00) ? 6'h01 : {1'b0, m} + 6'h01;
    r.post_ratio = (p < 3'h2) ? 4'h2 : {1'b0, p} + 4'h1;
    r.fb_ratio = (f < 12'h002) ? 12'h001 : f;
    r.pump_steps = (c == 4'h8) ? 5'h10 : ((c >= 4'h1 && c <= 4'h7) ? {1'b0, c} : 5'h00);
    return r;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // The request stands until the edge that sees pready high; the answer is taken there.
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      fails++;
      $display("Error at %0t: bus answer missing", $time);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic check_all();
    logic [31:0] q;
    logic e;
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, ADDR_W'({idx_tab[i], 2'b00}), 32'h0, q, e);
      chk(q, {24'h0, mdl[i]}, "register read");
      chk({31'h0, e}, 32'h0, "mapped read error");
    end
    chk(ratios, exp_ratio(), "decoded ratios");
    chk({31'h0, primary_ref_doubler_en}, {31'h0, mdl[2][4]}, "doubler enable");
    chk({31'h0, synth_a_resync_enable}, {31'h0, mdl[1][1]}, "resync enable");
  endtask

  task automatic wchk(input int i, input logic [7:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, ADDR_W'({idx_tab[i], 2'b00}), {24'hffffff, d}, q, e);
    mdl[i] = d & mask_tab[i];
    check_all();
  endtask

  task automatic do_reset();
    int n;
    reset_n <= 1'b0;
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    for (int i = 0; i < 5; i++) mdl[i] = rst_tab[i];
    n = 0;
    while (synth_a_cal_busy !== 1'b1 && n < 5) begin
      @(negedge clock);
      n++;
    end
    chk({31'h0, synth_a_enable}, 32'h1, "enabled after reset");
    n = 0;
    while (synth_a_cal_busy === 1'b1 && n < 3000) begin
      @(negedge clock);
      n++;
    end
    chk(32'(n >= 2498 && n <= 2502), 32'h1, "calibration length");
    check_all();
  endtask

  task automatic sync_try(input logic en);
    logic [CHANNELS-1:0] m;
    m = CHANNELS'($urandom);
    @(posedge clock);
    channel_on_synth_a <= m;
    sync_event <= 1'b1;
    @(posedge clock);
    sync_event <= 1'b0;
    @(negedge clock);
    chk(32'(channel_resync), en ? 32'(m) : 32'h0, "resync pulse");
    @(negedge clock);
    chk(32'(channel_resync), 32'h0, "resync pulse end");
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge clock);
    fails++;
    $display("Error at %0t: watchdog expired", $time);
    test_done();
  end

  initial begin
    logic [31:0] q;
    logic e;
    int n;
    fails = 0;
    check_count = 0;
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    sync_event = 1'b0;
    channel_on_synth_a = '0;
    void'($urandom(32'hc562));
    do_reset();
    $display("test reset done");
    foreach (corner[k]) wchk(int'(corner[k][15:8]), corner[k][7:0]);
    $display("test corners done");
    // Power-down stays clear here so calibration does not restart under random traffic.
    for (int k = 0; k < 40; k++) begin
      n = $urandom_range(0, 4);
      q = $urandom;
      if (n == 1) q[0] = 1'b0;
      wchk(n, q[7:0]);
    end
    $display("test random done");
    apb(1'b0, 12'h100, 32'h0, q, e);
    chk({e, q[30:0]}, 32'h80000000, "unmapped read");
    apb(1'b0, 12'he1, 32'h0, q, e);
    chk({31'h0, e}, 32'h1, "unaligned read error");
    apb(1'b1, 12'he3, 32'h000000ff, q, e);
    chk({31'h0, e}, 32'h1, "unaligned write error");
    apb(1'b1, 12'hf0, 32'h000000ff, q, e);
    chk({31'h0, e}, 32'h0, "status write");
    check_all();
    $display("test refused done");
    wchk(1, {mdl[1][7:2], 2'b10});
    repeat (8) sync_try(1'b1);
    wchk(1, {mdl[1][7:2], 2'b00});
    repeat (4) sync_try(1'b0);
    $display("test sync done");
    wchk(1, {mdl[1][7:1], 1'b1});
    repeat (3) @(negedge clock);
    chk({30'h0, synth_a_enable, synth_a_cal_reset}, 32'h1, "powered down");
    apb(1'b0, 12'hf0, 32'h0, q, e);
    chk(q, 32'h4, "status powered down");
    wchk(1, {mdl[1][7:1], 1'b0});
    chk({29'h0, synth_a_enable, synth_a_cal_busy, synth_a_cal_reset}, 32'h6, "recal");
    apb(1'b0, 12'hf0, 32'h0, q, e);
    chk(q, 32'h3, "status calibrating");
    n = 0;
    while (synth_a_cal_busy === 1'b1 && n < 3000) begin
      @(negedge clock);
      n++;
    end
    apb(1'b0, 12'hf0, 32'h0, q, e);
    chk(q, 32'h1, "status running");
    $display("test power done");
    do_reset();
    $display("test second reset done");
    test_done();
  end
endmodule

/* File: common/pll_regs_pkg.sv */
package pll_regs_pkg;

  // Clock and calibration timing.
  localparam int unsigned CLOCK_HZ = 25_000_000;
  localparam int unsigned CAL_TIME_US = 100;
  localparam int unsigned CAL_CYCLES = CAL_TIME_US * (CLOCK_HZ / 1_000_000);
  localparam int unsigned CAL_COUNT_W = 12;
  localparam logic [CAL_COUNT_W-1:0] CAL_LAST = CAL_COUNT_W'(CAL_CYCLES - 1);

  // Bus geometry.
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned INDEX_W = 8;
  localparam int unsigned CHANNELS = 8;

  // Register indices; the byte address is four times the index.
  localparam logic [INDEX_W-1:0] IDX_PLL2_M_DIV = 8'h37;
  localparam logic [INDEX_W-1:0] IDX_PLL1_CTRL_ZERO = 8'h38;
  localparam logic [INDEX_W-1:0] IDX_PLL1_CTRL_ONE = 8'h39;
  localparam logic [INDEX_W-1:0] IDX_PLL1_FB_HIGH = 8'h3a;
  localparam logic [INDEX_W-1:0] IDX_PLL1_FB_LOW = 8'h3b;
  localparam logic [INDEX_W-1:0] IDX_STATUS = 8'h3c;

  // Values after reset.
  localparam logic [7:0] RST_PLL2_M_DIV = 8'h00;
  localparam logic [7:0] RST_PLL1_CTRL_ZERO = 8'h1e;
  localparam logic [7:0] RST_PLL1_CTRL_ONE = 8'h18;
  localparam logic [7:0] RST_PLL1_FB_HIGH = 8'h00;
  localparam logic [7:0] RST_PLL1_FB_LOW = 8'h66;

  // Writable bits of each register; the rest read as zero.
  localparam logic [7:0] MASK_PLL2_M_DIV = 8'h1f;
  localparam logic [7:0] MASK_PLL1_CTRL_ZERO = 8'h1f;
  localparam logic [7:0] MASK_PLL1_CTRL_ONE = 8'h3f;
  localparam logic [7:0] MASK_PLL1_FB_HIGH = 8'h0f;

  // Field positions.
  localparam int unsigned POST_SEL_LSB = 2;
  localparam int unsigned RESYNC_EN_BIT = 1;
  localparam int unsigned POWER_DOWN_BIT = 0;
  localparam int unsigned DOUBLER_BIT = 4;
  localparam int unsigned PUMP_LSB = 0;
  localparam int unsigned STAT_ENABLED_BIT = 0;
  localparam int unsigned STAT_CAL_BUSY_BIT = 1;
  localparam int unsigned STAT_CAL_RESET_BIT = 2;

  // Charge pump: one step is 0.4 mA, the top code jumps to 6.4 mA.
  localparam int unsigned PUMP_STEP_UA = 400;
  localparam int unsigned PUMP_TOP_UA = 6400;
  localparam logic [3:0] PUMP_TOP_CODE = 4'h8;
  localparam logic [4:0] PUMP_TOP_STEPS = 5'(PUMP_TOP_UA / PUMP_STEP_UA);
  localparam logic [3:0] PUMP_LINEAR_LAST = 4'h7;

  localparam logic [2:0] POST_SEL_MIN_DIV2 = 3'h1;

  typedef enum logic [1:0] {ST_OFF, ST_CAL, ST_RUN} power_state_t;

  typedef struct packed {
    logic [4:0] m_code;
    logic [2:0] post_code;
    logic [11:0] fb_code;
    logic [3:0] pump_code;
  } div_codes_t;

  typedef struct packed {
    logic m_bypass;
    logic [5:0] m_ratio;
    logic [3:0] post_ratio;
    logic [11:0] fb_ratio;
    logic [4:0] pump_steps;
  } ratio_t;

endpackage

/* File: hw/pll_divider_control_regs.sv */
// How it works
// - M code zero bypasses, else divide k+1.
// - Post codes 0,1 divide 2; others code+1.
// - Sync event resyncs synth A channels when enabled.
// - Power-down zero enables and calibrates after reset.
// - Power-down one disables, resets calibration circuit.
// - Doubler bit, reset one, enables primary doubler.
// - Pump codes 1-7 step 0.4 mA; 8 is 6.4.
// - Feedback bits 11:8 in high byte, reset zero.
// - Feedback codes 0,1 give 1; else code.
// - Feedback low byte separate, resets to 0x66.
//
// Register access over APB was left to the implementer.
module pll_divider_control_regs
  import pll_regs_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sync_event,
  input wire logic [CHANNELS-1:0] channel_on_synth_a,
  output logic [CHANNELS-1:0] channel_resync,
  output ratio_t ratios,
  output logic synth_a_enable,
  output logic synth_a_cal_reset,
  output logic synth_a_cal_busy,
  output logic primary_ref_doubler_en,
  output logic synth_a_resync_enable
);

  function automatic logic reg_hit(input logic [ADDR_W-1:0] addr,
                                   input logic [INDEX_W-1:0] index);
    reg_hit = (addr[1:0] == 2'h0) && (addr[ADDR_W-1:2] == 10'(index));
  endfunction

  logic [7:0] pll2_reference_m_div;
  logic [7:0] pll1_control_zero;
  logic [7:0] pll1_control_one;
  logic [7:0] pll1_feedback_div_high;
  logic [7:0] pll1_feedback_div_low;
  logic [7:0] next_pll2_reference_m_div;
  logic [7:0] next_pll1_control_zero;
  logic [7:0] next_pll1_control_one;
  logic [7:0] next_pll1_feedback_div_high;
  logic [7:0] next_pll1_feedback_div_low;

  logic [DATA_W-1:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic write_fire;
  logic mapped;
  logic [7:0] read_byte;
  logic [7:0] status_byte;

  div_codes_t codes;
  ratio_t decoded;
  ratio_t next_ratios;
  logic [CHANNELS-1:0] next_channel_resync;

  logic synth_a_power_down;
  logic core_enable;
  logic core_cal_reset;
  logic core_cal_busy;

  // Field views of the stored registers.
  assign synth_a_power_down = pll1_control_zero[POWER_DOWN_BIT];
  assign synth_a_resync_enable = pll1_control_zero[RESYNC_EN_BIT];
  assign primary_ref_doubler_en = pll1_control_one[DOUBLER_BIT];
  assign codes.m_code = pll2_reference_m_div[4:0];
  assign codes.post_code = pll1_control_zero[POST_SEL_LSB +: 3];
  assign codes.pump_code = pll1_control_one[PUMP_LSB +: 4];
  assign codes.fb_code = {pll1_feedback_div_high[3:0], pll1_feedback_div_low};

  // The access takes effect only on the edge where pready is seen high.
  assign write_fire = psel && penable && pready && pwrite;

  always_comb begin
    mapped = reg_hit(paddr, IDX_PLL2_M_DIV) || reg_hit(paddr, IDX_PLL1_CTRL_ZERO) ||
             reg_hit(paddr, IDX_PLL1_CTRL_ONE) || reg_hit(paddr, IDX_PLL1_FB_HIGH) ||
             reg_hit(paddr, IDX_PLL1_FB_LOW) || reg_hit(paddr, IDX_STATUS);
    status_byte = '0;
    status_byte[STAT_ENABLED_BIT] = core_enable;
    status_byte[STAT_CAL_BUSY_BIT] = core_cal_busy;
    status_byte[STAT_CAL_RESET_BIT] = core_cal_reset;
    read_byte = '0;
    if (reg_hit(paddr, IDX_PLL2_M_DIV)) begin
      read_byte = pll2_reference_m_div;
    end else if (reg_hit(paddr, IDX_PLL1_CTRL_ZERO)) begin
      read_byte = pll1_control_zero;
    end else if (reg_hit(paddr, IDX_PLL1_CTRL_ONE)) begin
      read_byte = pll1_control_one;
    end else if (reg_hit(paddr, IDX_PLL1_FB_HIGH)) begin
      read_byte = pll1_feedback_div_high;
    end else if (reg_hit(paddr, IDX_PLL1_FB_LOW)) begin
      read_byte = pll1_feedback_div_low;
    end else if (reg_hit(paddr, IDX_STATUS)) begin
      read_byte = status_byte;
    end
  end

  // Bus answer: pready rises one cycle into the access phase and lasts one cycle.
  always_comb begin
    next_pready = psel && penable && !pready;
    next_pslverr = 1'b0;
    next_prdata = prdata;
    if (next_pready) begin
      next_pslverr = !mapped;
      next_prdata = (!pwrite && mapped) ? {24'h000000, read_byte} : '0;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= next_pready;
      pslverr <= next_pslverr;
      prdata <= next_prdata;
    end
  end

  // Register file; reserved bits are masked so they always read as zero.
  always_comb begin
    next_pll2_reference_m_div = pll2_reference_m_div;
    next_pll1_control_zero = pll1_control_zero;
    next_pll1_control_one = pll1_control_one;
    next_pll1_feedback_div_high = pll1_feedback_div_high;
    next_pll1_feedback_div_low = pll1_feedback_div_low;
    if (write_fire) begin
      if (reg_hit(paddr, IDX_PLL2_M_DIV)) begin
        next_pll2_reference_m_div = pwdata[7:0] & MASK_PLL2_M_DIV;
      end
      if (reg_hit(paddr, IDX_PLL1_CTRL_ZERO)) begin
        next_pll1_control_zero = pwdata[7:0] & MASK_PLL1_CTRL_ZERO;
      end
      if (reg_hit(paddr, IDX_PLL1_CTRL_ONE)) begin
        next_pll1_control_one = pwdata[7:0] & MASK_PLL1_CTRL_ONE;
      end
      if (reg_hit(paddr, IDX_PLL1_FB_HIGH)) begin
        next_pll1_feedback_div_high = pwdata[7:0] & MASK_PLL1_FB_HIGH;
      end
      if (reg_hit(paddr, IDX_PLL1_FB_LOW)) begin
        next_pll1_feedback_div_low = pwdata[7:0];
      end
    end
  end

  // Reset values stand in for the start-up load from non-volatile storage.
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      pll2_reference_m_div <= RST_PLL2_M_DIV;
      pll1_control_zero <= RST_PLL1_CTRL_ZERO;
      pll1_control_one <= RST_PLL1_CTRL_ONE;
      pll1_feedback_div_high <= RST_PLL1_FB_HIGH;
      pll1_feedback_div_low <= RST_PLL1_FB_LOW;
    end else begin
      pll2_reference_m_div <= next_pll2_reference_m_div;
      pll1_control_zero <= next_pll1_control_zero;
      pll1_control_one <= next_pll1_control_one;
      pll1_feedback_div_high <= next_pll1_feedback_div_high;
      pll1_feedback_div_low <= next_pll1_feedback_div_low;
    end
  end

  ratio_decode u_ratio_decode (
    .codes(codes),
    .ratios(decoded)
  );

  synth_power_ctrl u_power (
    .clock(clock),
    .reset_n(reset_n),
    .power_down(synth_a_power_down),
    .synth_enable(core_enable),
    .cal_reset(core_cal_reset),
    .cal_busy(core_cal_busy)
  );

  // Divider settings are registered so the analog side sees glitch-free codes.
  always_comb begin
    next_ratios = decoded;
  end

  // Each channel fed by synth A is pulsed on a sync event while resync is enabled, one cycle late.
  generate
    for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_resync
      always_comb begin
        next_channel_resync[ch] = sync_event && synth_a_resync_enable &&
                                  channel_on_synth_a[ch];
      end
    end
  endgenerate

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      ratios <= '0;
      channel_resync <= '0;
      synth_a_enable <= 1'b0;
      synth_a_cal_reset <= 1'b0;
      synth_a_cal_busy <= 1'b0;
    end else begin
      ratios <= next_ratios;
      channel_resync <= next_channel_resync;
      synth_a_enable <= core_enable;
      synth_a_cal_reset <= core_cal_reset;
      synth_a_cal_busy <= core_cal_busy;
    end
  end

  AST_M_BYPASS: assert property (@(posedge clock) disable iff (!reset_n)
    reset_n && codes.m_code == 5'h00 |=> ratios.m_bypass && ratios.m_ratio == 6'h01)
    else $error("zero M code did not bypass");

  AST_M_RATIO: assert property (@(posedge clock) disable iff (!reset_n)
    codes.m_code != 5'h00 |=> !ratios.m_bypass &&
      ratios.m_ratio == {1'b0, $past(codes.m_code)} + 6'h01)
    else $error("M ratio is not code plus one");

  AST_POST_RATIO: assert property (@(posedge clock) disable iff (!reset_n)
    reset_n |=> ratios.post_ratio == (($past(codes.post_code) < 3'h2) ? 4'h2 :
      {1'b0, $past(codes.post_code)} + 4'h1))
    else $error("post divider ratio mismatch");

  AST_RESYNC: assert property (@(posedge clock) disable iff (!reset_n)
    ##1 channel_resync == ($past(sync_event) && $past(synth_a_resync_enable) ?
      $past(channel_on_synth_a) : 8'h00))
    else $error("channel resync pulse mismatch");

  AST_PDN_OUTPUT: assert property (@(posedge clock) disable iff (!reset_n)
    synth_a_power_down |-> ##2 !synth_a_enable && synth_a_cal_reset)
    else $error("power down did not reach the synthesizer outputs");

  AST_DOUBLER: assert property (@(posedge clock) disable iff (!reset_n)
    write_fire && reg_hit(paddr, IDX_PLL1_CTRL_ONE) |=>
      primary_ref_doubler_en == $past(pwdata[DOUBLER_BIT]))
    else $error("doubler enable did not follow the write");

  AST_PUMP: assert property (@(posedge clock) disable iff (!reset_n)
    reset_n && codes.pump_code == PUMP_TOP_CODE |=> ratios.pump_steps == 5'h10)
    else $error("top pump code is not sixteen steps");

  AST_FB_HIGH: assert property (@(posedge clock) disable iff (!reset_n)
    reset_n && codes.fb_code >= 12'h002 |=>
      ratios.fb_ratio[11:8] == $past(pll1_feedback_div_high[3:0]))
    else $error("feedback high byte did not reach ratio bits 11 to 8");

  AST_FB_RATIO: assert property (@(posedge clock) disable iff (!reset_n)
    codes.fb_code < 12'h002 |=> ratios.fb_ratio == 12'h001)
    else $error("feedback codes 0 and 1 must give ratio 1");

  AST_FB_LOW_RESET: assert property (@(posedge clock)
    !reset_n |=> pll1_feedback_div_low == 8'h66)
    else $error("feedback low byte did not reset to 0x66");

  AST_READY_PULSE: assert property (@(posedge clock) disable iff (!reset_n)
    pready |=> !pready)
    else $error("pready held for more than one cycle");

  // The sampled reset in the antecedents of AST_M_BYPASS, AST_POST_RATIO, AST_PUMP and AST_FB_HIGH keeps the release edge,
  // where outputs still hold their reset values, out of those four checks.
  AST_READY_ANSWER: assert property (@(posedge clock) disable iff (!reset_n)
    psel && penable && !pready |=> pready)
    else $error("access phase was not answered");

  AST_SLVERR: assert property (@(posedge clock) disable iff (!reset_n)
    pready |-> pslverr == !$past(mapped))
    else $error("error response does not match the address map");

  AST_READ_DATA: assert property (@(posedge clock) disable iff (!reset_n)
    pready && !$past(pwrite) && $past(mapped) |->
      prdata == {24'h000000, $past(read_byte)})
    else $error("read data does not match the addressed register");

  AST_M_WRITE: assert property (@(posedge clock) disable iff (!reset_n)
    write_fire && reg_hit(paddr, IDX_PLL2_M_DIV) |=>
      pll2_reference_m_div == ($past(pwdata[7:0]) & MASK_PLL2_M_DIV))
    else $error("M divider write did not land masked");

  AST_FB_LOW_WRITE: assert property (@(posedge clock) disable iff (!reset_n)
    write_fire && reg_hit(paddr, IDX_PLL1_FB_LOW) |=>
      pll1_feedback_div_low == $past(pwdata[7:0]))
    else $error("feedback low byte write did not land");

  AST_ERROR_NO_WRITE: assert property (@(posedge clock) disable iff (!reset_n)
    write_fire && !mapped |=> $stable(pll1_control_zero) &&
      $stable(pll2_reference_m_div) && $stable(pll1_feedback_div_low))
    else $error("refused write changed a register");

  AST_CTRL_ZERO_RESET: assert property (@(posedge clock)
    !reset_n |=> pll1_control_zero == RST_PLL1_CTRL_ZERO)
    else $error("control zero did not take its reset value");

  AST_CTRL_ONE_RESET: assert property (@(posedge clock)
    !reset_n |=> pll1_control_one == RST_PLL1_CTRL_ONE)
    else $error("control one did not take its reset value");

  AST_RESYNC_REFUSED: assert property (@(posedge clock) disable iff (!reset_n)
    !synth_a_resync_enable |=> channel_resync == '0)
    else $error("resync pulse while resync was disabled");

endmodule

/* File: hw/ratio_decode.sv */
module ratio_decode
  import pll_regs_pkg::*;
(
  input wire div_codes_t codes,
  output ratio_t ratios
);

  always_comb begin
    ratios = '0;
    ratios.m_bypass = (codes.m_code == 5'h00);
    ratios.m_ratio = ratios.m_bypass ? 6'h01 : 6'({1'b0, codes.m_code} + 6'h01);
    if (codes.post_code <= POST_SEL_MIN_DIV2) begin
      ratios.post_ratio = 4'h2;
    end else begin
      ratios.post_ratio = 4'({1'b0, codes.post_code} + 4'h1);
    end
    ratios.fb_ratio = (codes.fb_code < 12'h002) ? 12'h001 : codes.fb_code;
    // Codes 0 and 9 to 15 have no defined current, so the pump is held off.
    if (codes.pump_code == PUMP_TOP_CODE) begin
      ratios.pump_steps = PUMP_TOP_STEPS;
    end else if (codes.pump_code <= PUMP_LINEAR_LAST) begin
      ratios.pump_steps = {1'b0, codes.pump_code};
    end else begin
      ratios.pump_steps = 5'h00;
    end
  end

endmodule

/* File: hw/synth_power_ctrl.sv */
module synth_power_ctrl
  import pll_regs_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic power_down,
  output logic synth_enable,
  output logic cal_reset,
  output logic cal_busy
);

  power_state_t state;
  power_state_t next_state;
  logic [CAL_COUNT_W-1:0] cal_count;
  logic [CAL_COUNT_W-1:0] next_cal_count;

  always_comb begin
    next_state = state;
    next_cal_count = cal_count;
    unique case (state)
      ST_OFF: begin
        if (!power_down) begin
          next_state = ST_CAL;
          next_cal_count = '0;
        end
      end
      ST_CAL: begin
        if (cal_count == CAL_LAST) begin
          next_state = ST_RUN;
        end else begin
          next_cal_count = cal_count + 1'b1;
        end
      end
      ST_RUN: begin
      end
    endcase
    if (power_down) begin
      next_state = ST_OFF;
      next_cal_count = '0;
    end
  end

  // Reset enters calibration because the power-down bit resets to zero.
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      state <= ST_CAL;
      cal_count <= '0;
    end else begin
      state <= next_state;
      cal_count <= next_cal_count;
    end
  end

  assign synth_enable = (state != ST_OFF);
  assign cal_reset = (state == ST_OFF);
  assign cal_busy = (state == ST_CAL);

  AST_PDN_DISABLES: assert property (@(posedge clock) disable iff (!reset_n)
    power_down |=> !synth_enable && cal_reset)
    else $error("power down did not disable the synthesizer");

  AST_PDN_RELEASE_CAL: assert property (@(posedge clock) disable iff (!reset_n)
    $fell(power_down) && !power_down |-> ##1 cal_busy)
    else $error("calibration did not start after power down cleared");

  AST_CAL_BOUNDED: assert property (@(posedge clock) disable iff (!reset_n)
    cal_busy |-> cal_count <= CAL_LAST)
    else $error("calibration counter ran past its end");

endmodule
